// ==== mms_seq.sv ====
// Purpose: mode and measurement sequencer with AXI4-Lite registers
// Assumes: sensor result inputs are valid when a measurement ends
// Notes: bus slave runs on rst_in only so soft reset never breaks a handshake
`default_nettype none
module mms_seq
	import mms_pkg::*;
#(
	parameter int unsigned P_MEAS_CYC = MEAS_CYC,
	parameter int unsigned P_PER_M1 = PER_M1_CYC,
	parameter int unsigned P_PER_M2 = PER_M2_CYC,
	parameter int unsigned P_PER_M3 = PER_M3_CYC,
	parameter int unsigned P_PER_M4 = PER_M4_CYC,
	parameter int unsigned P_PER_M5 = PER_M5_CYC,
	parameter int unsigned P_PER_M6 = PER_M6_CYC
) (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic reset_n_pin_in,
	input wire logic vid_present_in,
	input wire logic [15:0] sensor_x_in,
	input wire logic [15:0] sensor_y_in,
	input wire logic [15:0] sensor_z_in,
	input wire logic sensor_ovf_in,
	output logic data_ready_out,
	output logic meas_active_out,
	input wire logic [7:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [7:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in
);
	logic [1:0] pins_s;
	logic dev_rst;
	logic soft_reset_bit_q;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic wr_fire, ar_fire;
	logic mode_wr, soft_reset_bit_wr;
	logic [4:0] wr_code;
	logic data_rd, st2_rd, read_start;
	logic ready_q, overrun_q, lock_q, ovf_q;
	logic [15:0] x_q, y_q, z_q;
	logic [4:0] mode_q, mode_d;
	mms_state_e state_q, state_d;
	logic meas_start, per_start, stop_all;
	logic meas_done, per_done, store_ok;
	logic [31:0] per_load;
	logic [31:0] rd_word;
	logic rd_hit;

	// reset and supply pins come from outside the clock domain
	mms_sync #(
		.WIDTH(2),
		.RESET_VAL(2'h3)
	) u_pin_sync (
		.mclk_in(mclk_in),
		.rst_in(rst_in),
		.async_in({reset_n_pin_in, vid_present_in}),
		.sync_out(pins_s)
	);

	// every reset source acts alike on the device state
	assign dev_rst = rst_in | ~pins_s[1] | ~pins_s[0] | soft_reset_bit_q; // RL1 RL2 RL3

	// write address/data taken in either order, held until response
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			s_axi_awready_out <= 1'b1;
			awaddr_q <= 8'h00;
		end else if (s_axi_awvalid_in && s_axi_awready_out) begin
			s_axi_awready_out <= 1'b0;
			awaddr_q <= s_axi_awaddr_in;
		end else if (s_axi_bvalid_out && s_axi_bready_in) begin
			s_axi_awready_out <= 1'b1;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			s_axi_wready_out <= 1'b1;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
		end else if (s_axi_wvalid_in && s_axi_wready_out) begin
			s_axi_wready_out <= 1'b0;
			wdata_q <= s_axi_wdata_in;
			wstrb_q <= s_axi_wstrb_in;
		end else if (s_axi_bvalid_out && s_axi_bready_in) begin
			s_axi_wready_out <= 1'b1;
		end
	end

	// the write acts once both halves are held
	assign wr_fire = !s_axi_awready_out && !s_axi_wready_out && !s_axi_bvalid_out;
	assign wr_code = wdata_q[4:0];
	assign mode_wr = wr_fire && awaddr_q == ADDR_OP_CONTROL && wstrb_q[0]; // RL4
	assign soft_reset_bit_wr = wr_fire && awaddr_q == ADDR_SOFT_RESET && wstrb_q[0] && wdata_q[BIT_SOFT_RESET];

	// write response; unmapped addresses answer slverr
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			s_axi_bvalid_out <= 1'b0;
			s_axi_bresp_out <= RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid_out <= 1'b1;
			s_axi_bresp_out <= (awaddr_q <= ADDR_SEQ_STATE && awaddr_q[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready_in) begin
			s_axi_bvalid_out <= 1'b0;
		end
	end

	// soft reset is a one-cycle pulse that clears itself through dev_rst
	always_ff @(posedge mclk_in) begin
		if (dev_rst) begin
			soft_reset_bit_q <= 1'b0;
		end else begin
			soft_reset_bit_q <= soft_reset_bit_wr; // RL2
		end
	end

	// read side: arready drops while the answer is pending
	assign ar_fire = s_axi_arvalid_in && s_axi_arready_out;
	assign data_rd = ar_fire && s_axi_araddr_in >= ADDR_X_LOW && s_axi_araddr_in <= ADDR_LAST_DATA
		&& s_axi_araddr_in[1:0] == 2'h0;
	assign st2_rd = ar_fire && s_axi_araddr_in == ADDR_STATUS_SECOND;
	assign read_start = data_rd | st2_rd; // RL18

	// register read mux; stored result only, so reads never wait
	always_comb begin
		rd_word = 32'h0000_0000;
		rd_hit = 1'b1;
		unique case (s_axi_araddr_in)
			ADDR_STATUS_FIRST: begin
				rd_word[BIT_DATA_READY] = ready_q;
				rd_word[BIT_DATA_OVERRUN] = overrun_q; // RL17
			end
			ADDR_X_LOW: rd_word[7:0] = x_q[7:0]; // RL12
			ADDR_X_HIGH: rd_word[7:0] = x_q[15:8];
			ADDR_Y_LOW: rd_word[7:0] = y_q[7:0];
			ADDR_Y_HIGH: rd_word[7:0] = y_q[15:8];
			ADDR_Z_LOW: rd_word[7:0] = z_q[7:0];
			ADDR_Z_HIGH: rd_word[7:0] = z_q[15:8];
			ADDR_LAST_DATA: rd_word = 32'h0000_0000;
			ADDR_STATUS_SECOND: rd_word[BIT_SENSOR_OVF] = ovf_q; // RL21
			ADDR_OP_CONTROL: rd_word[4:0] = mode_q; // RL7
			ADDR_SOFT_RESET: rd_word = 32'h0000_0000;
			ADDR_SEQ_STATE: rd_word[2:0] = state_q;
			default: rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			s_axi_arready_out <= 1'b1;
			s_axi_rvalid_out <= 1'b0;
			s_axi_rdata_out <= 32'h0000_0000;
			s_axi_rresp_out <= RESP_OKAY;
		end else if (ar_fire) begin
			s_axi_arready_out <= 1'b0;
			s_axi_rvalid_out <= 1'b1;
			s_axi_rdata_out <= rd_word;
			s_axi_rresp_out <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rvalid_out && s_axi_rready_in) begin
			s_axi_arready_out <= 1'b1;
			s_axi_rvalid_out <= 1'b0;
		end
	end

	// interval length of the current periodic code
	function automatic logic [31:0] period_of(input logic [4:0] code);
		unique case (code)
			MODE_CONT1: return P_PER_M1[31:0];
			MODE_CONT2: return P_PER_M2[31:0];
			MODE_CONT3: return P_PER_M3[31:0];
			MODE_CONT4: return P_PER_M4[31:0];
			MODE_CONT5: return P_PER_M5[31:0];
			MODE_CONT6: return P_PER_M6[31:0];
			default: return P_PER_M1[31:0];
		endcase
	endfunction

	// mode sequencing; illegal active-to-active writes are ignored
	always_comb begin
		state_d = state_q;
		mode_d = mode_q;
		meas_start = 1'b0;
		per_start = 1'b0;
		stop_all = 1'b0;
		per_load = period_of(mode_q);
		unique case (state_q)
			ST_PDN: begin
				if (mode_wr && mms_is_active(wr_code)) begin // RL4 RL8 RL13
					state_d = ST_MEAS;
					mode_d = wr_code;
					meas_start = 1'b1;
					per_start = mms_is_periodic(wr_code);
					per_load = period_of(wr_code);
				end
			end
			ST_MEAS, ST_IDLE: begin
				if (mode_wr && wr_code == MODE_PDN) begin // RL13
					state_d = ST_PDN;
					mode_d = MODE_PDN;
					stop_all = 1'b1;
				end else if (mode_wr && mms_is_periodic(wr_code) && mms_is_periodic(mode_q)) begin
					state_d = ST_MEAS; // RL15
					mode_d = wr_code;
					meas_start = 1'b1;
					per_start = 1'b1;
					per_load = period_of(wr_code);
				end else if (state_q == ST_MEAS && meas_done) begin
					if (mms_is_periodic(mode_q)) begin
						state_d = ST_IDLE; // RL14 RL16
					end else begin
						state_d = ST_PDN; // RL9
						mode_d = MODE_PDN;
					end
				end else if (state_q == ST_IDLE && per_done) begin
					state_d = ST_MEAS; // RL14
					meas_start = 1'b1;
					per_start = 1'b1;
				end
			end
			default: begin
				state_d = ST_PDN;
				mode_d = MODE_PDN;
				stop_all = 1'b1;
			end
		endcase
	end

	always_ff @(posedge mclk_in) begin
		if (dev_rst) begin
			state_q <= ST_PDN; // RL1
			mode_q <= MODE_PDN;
			meas_active_out <= 1'b0;
		end else begin
			state_q <= state_d;
			mode_q <= mode_d;
			meas_active_out <= state_d == ST_MEAS;
		end
	end

	// measurement length and sample interval counters
	mms_timer #(
		.WIDTH(32)
	) u_meas_tmr (
		.mclk_in(mclk_in),
		.rst_in(dev_rst),
		.start_in(meas_start),
		.stop_in(stop_all),
		.load_in(P_MEAS_CYC[31:0]),
		.done_out(meas_done)
	); // RL24

	// restart acts one cycle after done, so load one short to keep start-to-start at the period
	mms_timer #(
		.WIDTH(32)
	) u_per_tmr (
		.mclk_in(mclk_in),
		.rst_in(dev_rst),
		.start_in(per_start),
		.stop_in(stop_all),
		.load_in(per_load - 32'h0000_0001),
		.done_out(per_done)
	); // RL24

	// result is dropped while a host read holds the old one
	assign store_ok = state_q == ST_MEAS && meas_done && !stop_all && !lock_q; // RL19

	// data registers move only at a stored measurement end
	always_ff @(posedge mclk_in) begin
		if (dev_rst) begin
			x_q <= 16'h0000;
			y_q <= 16'h0000;
			z_q <= 16'h0000;
			ovf_q <= 1'b0;
		end else if (store_ok) begin
			x_q <= sensor_x_in; // RL8
			y_q <= sensor_y_in;
			z_q <= sensor_z_in;
			ovf_q <= sensor_ovf_in; // RL22
		end
	end

	// ready: a new result wins over a read start in the same cycle
	always_ff @(posedge mclk_in) begin
		if (dev_rst) begin
			ready_q <= 1'b0;
		end else if (store_ok) begin
			ready_q <= 1'b1; // RL9 RL16
		end else if (read_start) begin
			ready_q <= 1'b0; // RL10
		end
	end

	// a result lost to protection or left unread marks a skip
	always_ff @(posedge mclk_in) begin
		if (dev_rst) begin
			overrun_q <= 1'b0;
		end else if (state_q == ST_MEAS && meas_done && !stop_all && (lock_q || ready_q)) begin
			overrun_q <= 1'b1; // RL23
		end else if (read_start) begin
			overrun_q <= 1'b0; // RL18
		end
	end

	// protection from first data read until status_second is read
	always_ff @(posedge mclk_in) begin
		if (dev_rst) begin
			lock_q <= 1'b0;
		end else if (st2_rd) begin
			lock_q <= 1'b0; // RL19
		end else if (data_rd) begin
			lock_q <= 1'b1;
		end
	end

	// pin mirrors the flag flop directly
	assign data_ready_out = ready_q; // RL11
endmodule // mms_seq
`default_nettype wire

// ==== mms_pkg.sv ====
// Purpose: constants of the magnetometer mode sequencer
// Assumes: 100 MHz internal clock, AXI4-Lite register access
// Notes: byte addresses, one register per aligned word
// Contract
// RL1 - any reset initialises registers, device then sits in power-down.
// RL2 - writing one to soft_reset_bit resets like other sources.
// RL3 - reset_n_pin low or interface supply off holds device in reset.
// RL4 - nine modes, started by writing 5-bit mode field of op_control_reg.
// RL5 - host writes power-down before any other mode, never active to active.
// RL6 - host waits 100 us after power-down before another mode code.
// RL7 - power-down keeps all registers accessible and contents retained.
// RL8 - code 00001 takes one measurement and stores three axis results.
// RL9 - single done: back to power-down, mode 00000, data_ready_flag set.
// RL10 - data_ready_flag clears on data or status_second read, else holds.
// RL11 - data ready pin always equals data_ready_flag.
// RL12 - during measurement data registers keep old result, reads never stall.
// RL13 - six periodic codes measure at 10,20,50,100,200,1 Hz until power-down.
// RL14 - between samples only interval counter runs, wakes for next measurement.
// RL15 - periodic code during periodic mode restarts, status and data kept.
// RL16 - periodic: data_ready_flag set on entering idle with stored result.
// RL17 - data_overrun_flag reads one when results were skipped.
// RL18 - data or status_second read starts data read, clears both flags.
// RL19 - stored result protected from read start until status_second read.
// RL20 - host waits data ready, reads status_first, data, then status_second.
// RL21 - sensor_overflow_flag shows overflow of the stored measurement.
// RL22 - sensor_overflow_flag refreshed with every axis data update.
// RL23 - unread result at next measurement end: ready kept, overrun set.
// RL24 - measurement and interval timed by counters with parameter limits.
`default_nettype none
package mms_pkg;
	localparam int unsigned CLK_FREQ_HZ = 100_000_000;
	localparam real CLK_PERIOD_NS = 10.0;
	localparam real MEAS_TIME_MS = 4.5;
	localparam int unsigned MEAS_CYC = int'($ceil(MEAS_TIME_MS * 1.0e6 / CLK_PERIOD_NS));
	localparam int unsigned MODE_WAIT_US = 100;
	localparam int unsigned MODE_WAIT_CYC = MODE_WAIT_US * 1000 / 10;
	localparam int unsigned FREQ_M1_HZ = 10;
	localparam int unsigned FREQ_M2_HZ = 20;
	localparam int unsigned FREQ_M3_HZ = 50;
	localparam int unsigned FREQ_M4_HZ = 100;
	localparam int unsigned FREQ_M5_HZ = 200;
	localparam int unsigned FREQ_M6_HZ = 1;
	localparam int unsigned PER_M1_CYC = CLK_FREQ_HZ / FREQ_M1_HZ;
	localparam int unsigned PER_M2_CYC = CLK_FREQ_HZ / FREQ_M2_HZ;
	localparam int unsigned PER_M3_CYC = CLK_FREQ_HZ / FREQ_M3_HZ;
	localparam int unsigned PER_M4_CYC = CLK_FREQ_HZ / FREQ_M4_HZ;
	localparam int unsigned PER_M5_CYC = CLK_FREQ_HZ / FREQ_M5_HZ;
	localparam int unsigned PER_M6_CYC = CLK_FREQ_HZ / FREQ_M6_HZ;
	// mode codes
	localparam logic [4:0] MODE_PDN = 5'h00;
	localparam logic [4:0] MODE_SINGLE = 5'h01;
	localparam logic [4:0] MODE_CONT1 = 5'h02;
	localparam logic [4:0] MODE_CONT2 = 5'h04;
	localparam logic [4:0] MODE_CONT3 = 5'h06;
	localparam logic [4:0] MODE_CONT4 = 5'h08;
	localparam logic [4:0] MODE_CONT5 = 5'h0A;
	localparam logic [4:0] MODE_CONT6 = 5'h0C;
	localparam logic [4:0] MODE_SELFTEST = 5'h10;
	// register byte addresses
	localparam logic [7:0] ADDR_STATUS_FIRST = 8'h00;
	localparam logic [7:0] ADDR_X_LOW = 8'h04;
	localparam logic [7:0] ADDR_X_HIGH = 8'h08;
	localparam logic [7:0] ADDR_Y_LOW = 8'h0C;
	localparam logic [7:0] ADDR_Y_HIGH = 8'h10;
	localparam logic [7:0] ADDR_Z_LOW = 8'h14;
	localparam logic [7:0] ADDR_Z_HIGH = 8'h18;
	localparam logic [7:0] ADDR_LAST_DATA = 8'h1C;
	localparam logic [7:0] ADDR_STATUS_SECOND = 8'h20;
	localparam logic [7:0] ADDR_OP_CONTROL = 8'h24;
	localparam logic [7:0] ADDR_SOFT_RESET = 8'h28;
	localparam logic [7:0] ADDR_SEQ_STATE = 8'h2C;
	// field positions
	localparam int unsigned BIT_DATA_READY = 0;
	localparam int unsigned BIT_DATA_OVERRUN = 1;
	localparam int unsigned BIT_SENSOR_OVF = 3;
	localparam int unsigned BIT_SOFT_RESET = 0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {
		ST_PDN = 3'b001,
		ST_MEAS = 3'b010,
		ST_IDLE = 3'b100
	} mms_state_e;
	function automatic logic mms_is_periodic(input logic [4:0] code);
		return code == MODE_CONT1 || code == MODE_CONT2 || code == MODE_CONT3 ||
			code == MODE_CONT4 || code == MODE_CONT5 || code == MODE_CONT6;
	endfunction
	function automatic logic mms_is_active(input logic [4:0] code);
		return mms_is_periodic(code) || code == MODE_SINGLE || code == MODE_SELFTEST;
	endfunction
endpackage
`default_nettype wire

// ==== mms_sync.sv ====
// Purpose: two-stage synchroniser for pins from outside the clock domain
// Assumes: synchronous reset
// Notes: first stage feeds only the second stage
`default_nettype none
module mms_sync #(
	parameter int unsigned WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;
	// two flops, reset to an inactive level
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			meta_q <= RESET_VAL;
			sync_out <= RESET_VAL;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule // mms_sync
`default_nettype wire

// ==== mms_timer.sv ====
// Purpose: loadable down counter giving a one-cycle done pulse
// Assumes: load value of at least one
// Notes: stop wins over start
`default_nettype none
module mms_timer #(
	parameter int unsigned WIDTH = 32
) (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic start_in,
	input wire logic stop_in,
	input wire logic [WIDTH-1:0] load_in,
	output logic done_out
);
	logic [WIDTH-1:0] cnt_q;
	logic run_q;
	// count load_in cycles from start to done
	always_ff @(posedge mclk_in) begin
		if (rst_in || stop_in) begin
			cnt_q <= '0;
			run_q <= 1'b0;
			done_out <= 1'b0;
		end else if (start_in) begin
			cnt_q <= load_in - 1'b1;
			run_q <= 1'b1;
			done_out <= 1'b0;
		end else if (run_q && cnt_q == '0) begin
			run_q <= 1'b0;
			done_out <= 1'b1;
		end else begin
			cnt_q <= run_q ? cnt_q - 1'b1 : cnt_q;
			done_out <= 1'b0;
		end
	end
endmodule // mms_timer
`default_nettype wire

// ==== mms_seq_chk.sv ====
// Purpose: port checker for mms_seq
// Assumes: rst_in synchronous, active high
// Notes: bound by module name below
`default_nettype none
module mms_seq_chk #(
	parameter int unsigned P_MEAS_CYC = 20
) (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic vid_present_in,
	input wire logic data_ready_out,
	input wire logic meas_active_out,
	input wire logic s_axi_awvalid_in,
	input wire logic s_axi_awready_out,
	input wire logic s_axi_wvalid_in,
	input wire logic s_axi_wready_out,
	input wire logic s_axi_bvalid_out,
	input wire logic [7:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	input wire logic s_axi_arready_out,
	input wire logic s_axi_rvalid_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge mclk_in); endclocking
	default disable iff (rst_in);
	localparam int MLO = P_MEAS_CYC - 1;
	localparam int MHI = P_MEAS_CYC + 1;
	logic [31:0] act_q;
	logic ar_data;
	// read of a data word or the second status word
	assign ar_data = s_axi_araddr_in[1:0] == 2'h0 && s_axi_araddr_in >= 8'h04 && s_axi_araddr_in <= 8'h20;
	// cycles spent in the current measurement
	always_ff @(posedge mclk_in) begin
		if (rst_in || !meas_active_out) act_q <= '0;
		else act_q <= act_q + 32'h1;
	end
	AST_RST_IDLE: assert property (disable iff (1'b0) rst_in |=> !data_ready_out && !meas_active_out)
		else $error("outputs not idle after reset");
	AST_VID_HOLD: assert property (!vid_present_in [*4] |-> !data_ready_out && !meas_active_out)
		else $error("supply loss does not hold reset");
	AST_MEAS_LEN: assert property ($rose(data_ready_out) |-> (act_q inside {[MLO:MHI]}) ||
		($past(act_q) inside {[MLO:MHI]})) else $error("measurement length wrong");
	AST_RDY_SRC: assert property ($rose(data_ready_out) |-> !meas_active_out)
		else $error("ready raised while measuring");
	AST_RD_CLR: assert property (s_axi_arvalid_in && s_axi_arready_out && ar_data && !meas_active_out
		|=> !data_ready_out) else $error("data read did not clear ready");
	AST_BRESP: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out
		|-> ##[1:2] s_axi_bvalid_out) else $error("write answer late");
	AST_RRESP: assert property (s_axi_arvalid_in && s_axi_arready_out |-> ##[1:2] s_axi_rvalid_out)
		else $error("read answer late");
	AST_WBUSY: assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
		else $error("write taken while answer pending");
	AST_RBUSY: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
		else $error("read taken while answer pending");
	C_MEAS: cover property ($fell(meas_active_out));
	C_RDY: cover property ($rose(data_ready_out));
	C_VID: cover property (!vid_present_in [*4]);
endmodule // mms_seq_chk
bind mms_seq mms_seq_chk #(.P_MEAS_CYC(P_MEAS_CYC)) chk_u (.*);
`default_nettype wire

// ==== mms_host.sv ====
// Purpose: host model on the register bus of mms_seq
// Assumes: tasks are called from the bench, one at a time
// Notes: hang_out rises when an answer never comes
`default_nettype none
module mms_host (
	input wire logic mclk_in,
	output logic [7:0] awaddr_out,
	output logic awvalid_out,
	input wire logic awready_in,
	output logic [31:0] wdata_out,
	output logic [3:0] wstrb_out,
	output logic wvalid_out,
	input wire logic wready_in,
	input wire logic [1:0] bresp_in,
	input wire logic bvalid_in,
	output logic bready_out,
	output logic [7:0] araddr_out,
	output logic arvalid_out,
	input wire logic arready_in,
	input wire logic [31:0] rdata_in,
	input wire logic [1:0] rresp_in,
	input wire logic rvalid_in,
	output logic rready_out,
	output logic hang_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// quiet bus from time zero
	initial begin
		{awaddr_out, awvalid_out, wdata_out, wvalid_out, bready_out} = '0;
		{araddr_out, arvalid_out, rready_out, hang_out} = '0;
		wstrb_out = 4'hF;
	end
	// both channels offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge mclk_in);
		n = 0;
		awaddr_out <= a;
		wdata_out <= d;
		awvalid_out <= 1'b1;
		wvalid_out <= 1'b1;
		bready_out <= 1'b1;
		do begin
			@(posedge mclk_in);
			n++;
			if (awready_in) awvalid_out <= 1'b0;
			if (wready_in) wvalid_out <= 1'b0;
		end while (!bvalid_in && n < 300);
		r = bresp_in;
		bready_out <= 1'b0;
		if (n >= 300) hang_out <= 1'b1;
	endtask
	// rready held up from the start, so no answer is missed
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge mclk_in);
		n = 0;
		araddr_out <= a;
		arvalid_out <= 1'b1;
		rready_out <= 1'b1;
		do begin
			@(posedge mclk_in);
			n++;
			if (arready_in) arvalid_out <= 1'b0;
		end while (!rvalid_in && n < 300);
		d = rdata_in;
		r = rresp_in;
		rready_out <= 1'b0;
		if (n >= 300) hang_out <= 1'b1;
	endtask
endmodule // mms_host
`default_nettype wire

// ==== tb_mms_seq.sv ====
// Purpose: self-checking bench for mms_seq
// Assumes: shortened measurement and period counts
// Notes: host_u speaks the register bus
`default_nettype none
module tb_mms_seq
	import mms_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int MC = 20;
	localparam int PER [6] = '{40, 50, 60, 70, 80, 100};
	localparam logic [4:0] CODE [6] = '{MODE_CONT1, MODE_CONT2, MODE_CONT3, MODE_CONT4, MODE_CONT5, MODE_CONT6};
	typedef struct packed {logic [7:0] a; logic [31:0] d; logic [1:0] r;} mms_row_s;
	mms_row_s rows [8] = '{'{ADDR_STATUS_FIRST, 32'h0, RESP_OKAY}, '{ADDR_X_LOW, 32'h0, RESP_OKAY},
		'{ADDR_Z_HIGH, 32'h0, RESP_OKAY}, '{ADDR_STATUS_SECOND, 32'h0, RESP_OKAY},
		'{ADDR_OP_CONTROL, 32'h0, RESP_OKAY}, '{ADDR_SEQ_STATE, 32'h1, RESP_OKAY},
		'{8'h30, 32'h0, RESP_SLVERR}, '{8'h02, 32'h0, RESP_SLVERR}};
	logic mclk_in = 1'b0;
	logic rst_in = 1'b1;
	logic reset_n_pin_in = 1'b1;
	logic vid_present_in = 1'b1;
	logic [15:0] sensor_x_in = 16'h1234;
	logic [15:0] sensor_y_in = 16'h5678;
	logic [15:0] sensor_z_in = 16'h9ABC;
	logic sensor_ovf_in = 1'b1;
	logic data_ready_out, meas_active_out, hang;
	logic [7:0] s_axi_awaddr_in, s_axi_araddr_in;
	logic [31:0] s_axi_wdata_in, s_axi_rdata_out, rd_d;
	logic [3:0] s_axi_wstrb_in;
	logic [1:0] s_axi_bresp_out, s_axi_rresp_out, rsp;
	logic s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in, s_axi_wready_out, s_axi_bvalid_out;
	logic s_axi_bready_in, s_axi_arvalid_in, s_axi_arready_out, s_axi_rvalid_out, s_axi_rready_in;
	int error_cnt = 0;
	int tests_run = 0;
	int n;
	always #5 mclk_in = ~mclk_in;
	mms_seq #(.P_MEAS_CYC(MC), .P_PER_M1(PER[0]), .P_PER_M2(PER[1]), .P_PER_M3(PER[2]),
		.P_PER_M4(PER[3]), .P_PER_M5(PER[4]), .P_PER_M6(PER[5])) dut_u (.*);
	mms_host host_u (.mclk_in(mclk_in), .awaddr_out(s_axi_awaddr_in), .awvalid_out(s_axi_awvalid_in),
		.awready_in(s_axi_awready_out), .wdata_out(s_axi_wdata_in), .wstrb_out(s_axi_wstrb_in),
		.wvalid_out(s_axi_wvalid_in), .wready_in(s_axi_wready_out), .bresp_in(s_axi_bresp_out),
		.bvalid_in(s_axi_bvalid_out), .bready_out(s_axi_bready_in), .araddr_out(s_axi_araddr_in),
		.arvalid_out(s_axi_arvalid_in), .arready_in(s_axi_arready_out), .rdata_in(s_axi_rdata_out),
		.rresp_in(s_axi_rresp_out), .rvalid_in(s_axi_rvalid_out), .rready_out(s_axi_rready_in),
		.hang_out(hang));
	task automatic tally_and_finish();
		$display("checks %0d, errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t ns: saw %h, wanted %h", $time, seen, exp);
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		host_u.rd(a, rd_d, rsp);
		check(rd_d, e);
	endtask
	// m selects the measuring flag, else the ready pin; bounded wait
	task automatic wait_for(input logic m, input logic v);
		int k;
		k = 0;
		while ((m ? meas_active_out : data_ready_out) !== v && k < 5000) begin
			@(posedge mclk_in);
			k++;
		end
		if (k >= 5000) begin
			error_cnt++;
			tally_and_finish();
		end
	endtask
	// park in power-down and let it settle before a new code
	task automatic set_mode(input logic [4:0] code);
		host_u.wr(ADDR_OP_CONTROL, 32'h0, rsp);
		repeat (MODE_WAIT_CYC) @(posedge mclk_in);
		host_u.wr(ADDR_OP_CONTROL, {27'h0, code}, rsp);
	endtask
	// a lost answer ends the run
	always @(posedge hang) begin
		error_cnt++;
		tally_and_finish();
	end
	initial begin
		repeat (10) @(posedge mclk_in);
		rst_in <= 1'b0;
		// reset contents and bus answers, unmapped and unaligned included
		foreach (rows[i]) begin
			host_u.rd(rows[i].a, rd_d, rsp);
			check({30'h0, rsp}, {30'h0, rows[i].r});
			if (rows[i].r == RESP_OKAY) check(rd_d, rows[i].d);
		end
		// single measurement with overflow
		set_mode(MODE_SINGLE);
		wait_for(1'b0, 1'b1);
		rchk(ADDR_STATUS_FIRST, 32'h1);
		rchk(ADDR_OP_CONTROL, 32'h0);
		rchk(ADDR_X_LOW, 32'h34);
		check({31'h0, data_ready_out}, 32'h0);
		rchk(ADDR_Z_HIGH, 32'h9A);
		rchk(ADDR_STATUS_SECOND, 32'h8);
		// self-test, reading old data while it measures
		sensor_x_in <= 16'hBEEF;
		sensor_ovf_in <= 1'b0;
		set_mode(MODE_SELFTEST);
		check({31'h0, meas_active_out}, 32'h1);
		rchk(ADDR_X_LOW, 32'h34);
		rchk(ADDR_STATUS_SECOND, 32'h8);
		wait_for(1'b0, 1'b1);
		rchk(ADDR_OP_CONTROL, 32'h0);
		rchk(ADDR_X_LOW, 32'hEF);
		rchk(ADDR_STATUS_SECOND, 32'h0);
		// every periodic code, restarted while running; start-to-start time
		set_mode(CODE[0]);
		for (int i = 0; i < 6; i++) begin
			wait_for(1'b1, 1'b0);
			host_u.wr(ADDR_OP_CONTROL, {27'h0, CODE[i]}, rsp);
			wait_for(1'b1, 1'b0);
			wait_for(1'b1, 1'b1);
			n = 0;
			while (meas_active_out && n < 400) begin
				@(posedge mclk_in);
				n++;
			end
			while (!meas_active_out && n < 400) begin
				@(posedge mclk_in);
				n++;
			end
			check(32'(n), 32'(PER[i]));
		end
		// unread results skipped, then a result dropped while protected
		rchk(ADDR_STATUS_FIRST, 32'h3);
		rchk(ADDR_X_LOW, 32'hEF);
		check({31'h0, data_ready_out}, 32'h0);
		sensor_x_in <= 16'h0102;
		wait_for(1'b1, 1'b1);
		wait_for(1'b1, 1'b0);
		rchk(ADDR_STATUS_FIRST, 32'h2);
		rchk(ADDR_X_LOW, 32'hEF);
		rchk(ADDR_STATUS_SECOND, 32'h0);
		wait_for(1'b1, 1'b1);
		wait_for(1'b0, 1'b1);
		rchk(ADDR_X_LOW, 32'h02);
		// soft reset in mid-run
		host_u.wr(ADDR_SOFT_RESET, 32'h1, rsp);
		check({30'h0, rsp}, {30'h0, RESP_OKAY});
		repeat (3) @(posedge mclk_in);
		check({31'h0, data_ready_out}, 32'h0);
		rchk(ADDR_OP_CONTROL, 32'h0);
		rchk(ADDR_X_LOW, 32'h0);
		rchk(ADDR_STATUS_SECOND, 32'h0);
		rchk(ADDR_SEQ_STATE, 32'h1);
		host_u.wr(8'h30, 32'h1, rsp);
		check({30'h0, rsp}, {30'h0, RESP_SLVERR});
		// reset pin, then supply loss
		host_u.wr(ADDR_OP_CONTROL, {27'h0, MODE_SINGLE}, rsp);
		wait_for(1'b0, 1'b1);
		reset_n_pin_in <= 1'b0;
		repeat (5) @(posedge mclk_in);
		reset_n_pin_in <= 1'b1;
		repeat (4) @(posedge mclk_in);
		check({31'h0, data_ready_out}, 32'h0);
		host_u.wr(ADDR_OP_CONTROL, {27'h0, MODE_SINGLE}, rsp);
		wait_for(1'b0, 1'b1);
		vid_present_in <= 1'b0;
		repeat (6) @(posedge mclk_in);
		check({31'h0, data_ready_out}, 32'h0);
		vid_present_in <= 1'b1;
		repeat (4) @(posedge mclk_in);
		rchk(ADDR_SEQ_STATE, 32'h1);
		tally_and_finish();
	end
endmodule // tb_mms_seq
`default_nettype wire
